// ---- adsp_pkg.sv ----
// Constants and types of the four-channel converter scan port
package adsp_pkg;

   ////////////////////////////////////////////////////////////////////////////
   localparam int DATA_W = 8;
   localparam int CHAN_N = 4;
   localparam int CHAN_W = 2;

   // Upper register (channel_control_status) point positions
   localparam int CCS_IND_LSB = 0;
   localparam int CCS_SEL_LO_BIT = 4;
   localparam int CCS_SEL_HI_BIT = 5;
   localparam int CCS_SINGLE_EN_BIT = 6;
   localparam int CCS_SCAN_ALL_BIT = 7;

   // Reset values and the channel range ends
   localparam logic [7:0] CONVERSION_DATA_RST = 8'h00;
   localparam logic [3:0] INDICATOR_RST = 4'h0;
   localparam logic [1:0] FIRST_CHANNEL = 2'h0;
   localparam logic [1:0] LAST_CHANNEL = 2'h3;

   // Code range of one result
   localparam logic [7:0] CODE_LOW_LIMIT = 8'h00;
   localparam logic [7:0] CODE_HIGH_LIMIT = 8'hff;

   // Timing: a conversion that takes longer than this is abandoned and the next channel requested
   localparam real CLOCK_MHZ = 100.0;
   localparam real CONV_TIME_MS = 2.0;
   localparam int CONV_TIMEOUT_CYC = int'(CONV_TIME_MS * 1000.0 * CLOCK_MHZ);

   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic scan_all;
      logic single_en;
      logic [1:0] select;
   } adsp_ctrl_s;

   localparam adsp_ctrl_s CTRL_RST = '{scan_all: 1'b0, single_en: 1'b0, select: 2'h0};

   typedef struct packed {
      logic ack;
      logic [7:0] data;
   } adsp_conv_s;

   typedef enum logic [1:0] {
      CONV_IDLE,
      CONV_REQ,
      CONV_RELEASE
   } adsp_conv_e;

endpackage : adsp_pkg

// ---- adsp_scan_port.sv ----
// Channel sequencing, result store and 16-point I/O image of the scan port
`timescale 1ns/100ps
// Overview of operation
// RULE1: One channel result presented per CPU scan; sequence wraps to channel 1.
// RULE2: No channel is skipped, so all-channel scan steps through channels 1 to 4 in turn.
// RULE3: Conversion runs continuously, independent of scans; handover follows scan.
// RULE4: Image is two 8-bit registers, some points CPU inputs, others CPU outputs.
// RULE5: Upper register top point enables all-channel scan; else single select applies.
// RULE6: First scan after enable shows channel 1; none shown when nothing selected.
// RULE7: Select points: 00 ch1, low-only ch2, high-only ch3, both ch4.
// RULE8: Single select points are ignored while all-channel scan is enabled.
// RULE9: Low four upper points are one-hot active channel indicators to the CPU.
// RULE10: Lower register holds presented result as unsigned binary, bit n weight 2^n.
// RULE11: Range low limit codes 0, high limit codes 255, linear steps.
// RULE12: CPU must read indicators on same scan to attribute shared data.
// RULE13: Data and indicators update together on the same scan boundary.
module adsp_scan_port #(
   parameter int CONV_TIMEOUT = adsp_pkg::CONV_TIMEOUT_CYC
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic scan_pulse,
   input wire logic image_out_wr,
   input wire logic [7:0] image_out_data,
   output logic [7:0] conversion_data,
   output logic [7:0] channel_control_status,
   output logic conv_req,
   output logic [adsp_pkg::CHAN_W-1:0] conv_channel,
   input wire logic conv_ack,
   input wire logic [adsp_pkg::DATA_W-1:0] conv_data
);
   import adsp_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // CPU output points
   adsp_ctrl_s ctrl_reg;
   logic prev_scan_all_reg;

   always_ff @(posedge clock) begin
      if (reset) begin
         ctrl_reg <= CTRL_RST;
      end else if (image_out_wr) begin
         // Indicator points are inputs to the CPU, so bits 3:0 of a write are dropped
         ctrl_reg.scan_all <= image_out_data[CCS_SCAN_ALL_BIT]; // see RULE4
         ctrl_reg.single_en <= image_out_data[CCS_SINGLE_EN_BIT];
         ctrl_reg.select <= {image_out_data[CCS_SEL_HI_BIT], image_out_data[CCS_SEL_LO_BIT]};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Converter handshake; the converter sits outside this clock, so sync its lines
   adsp_conv_s conv_meta_reg;
   adsp_conv_s conv_sync_reg;
   adsp_conv_e conv_state_reg;
   logic [31:0] conv_timer_reg;
   logic [DATA_W-1:0] result_mem [CHAN_N];

   always_ff @(posedge clock) begin
      if (reset) begin
         conv_meta_reg <= '0;
         conv_sync_reg <= '0;
      end else begin
         conv_meta_reg <= '{ack: conv_ack, data: conv_data};
         conv_sync_reg <= conv_meta_reg;
      end
   end

   // Free running round robin, unaware of the CPU scan timing
   always_ff @(posedge clock) begin
      if (reset) begin
         conv_state_reg <= CONV_IDLE;
         conv_req <= 1'b0;
         conv_channel <= FIRST_CHANNEL;
         conv_timer_reg <= '0;
      end else begin
         case (conv_state_reg)
            CONV_IDLE: begin
               if (!conv_sync_reg.ack) begin
                  conv_req <= 1'b1; // see RULE3
                  conv_timer_reg <= '0;
                  conv_state_reg <= CONV_REQ;
               end
            end
            CONV_REQ: begin
               conv_timer_reg <= conv_timer_reg + 32'h1;
               // Data is held stable by the converter while ack is high
               if (conv_sync_reg.ack) begin
                  conv_req <= 1'b0;
                  conv_state_reg <= CONV_RELEASE;
               end else if (conv_timer_reg >= 32'(CONV_TIMEOUT - 1)) begin
                  // A hung converter would freeze every channel; abandon and move on
                  conv_req <= 1'b0;
                  conv_state_reg <= CONV_RELEASE;
               end
            end
            CONV_RELEASE: begin
               if (!conv_sync_reg.ack) begin
                  conv_channel <= conv_channel + 2'h1; // see RULE3
                  conv_state_reg <= CONV_IDLE;
               end
            end
            default: begin
               conv_req <= 1'b0;
               conv_state_reg <= CONV_IDLE;
            end
         endcase
      end
   end

   // One result slot per channel, written only when that channel finished
   generate
      for (genvar ch = 0; ch < CHAN_N; ch++) begin : g_slot
         always_ff @(posedge clock) begin
            if (reset) begin
               result_mem[ch] <= CODE_LOW_LIMIT;
            end else if (conv_state_reg == CONV_REQ && conv_sync_reg.ack &&
                         conv_channel == CHAN_W'(ch)) begin
               // Unsigned 8-bit code, 00 at range low through ff at range high
               result_mem[ch] <= conv_sync_reg.data; // see RULE10 see RULE11
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Scan boundary: choose the channel to present
   logic [CHAN_W-1:0] shown_chan_reg;
   logic [CHAN_W-1:0] next_chan;
   logic next_valid;
   logic [3:0] indicator_reg;

   always_comb begin
      next_chan = shown_chan_reg;
      next_valid = 1'b0;
      if (ctrl_reg.scan_all) begin
         next_valid = 1'b1;
         // Select points are not looked at in this mode
         if (!prev_scan_all_reg || shown_chan_reg == LAST_CHANNEL) begin // see RULE8
            next_chan = FIRST_CHANNEL; // see RULE6 see RULE1
         end else begin
            next_chan = shown_chan_reg + 2'h1; // see RULE5 see RULE2
         end
      end else if (ctrl_reg.single_en) begin
         next_valid = 1'b1;
         next_chan = ctrl_reg.select; // see RULE7
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         prev_scan_all_reg <= 1'b0;
         shown_chan_reg <= FIRST_CHANNEL;
      end else if (scan_pulse) begin
         prev_scan_all_reg <= ctrl_reg.scan_all;
         shown_chan_reg <= next_chan;
      end
   end

   // Data and indicator change in the same edge so they never disagree
   always_ff @(posedge clock) begin
      if (reset) begin
         conversion_data <= CONVERSION_DATA_RST;
         indicator_reg <= INDICATOR_RST;
      end else if (scan_pulse) begin
         if (next_valid) begin
            conversion_data <= result_mem[next_chan]; // see RULE13 see RULE1
            indicator_reg <= 4'h1 << next_chan; // see RULE9
         end else begin
            indicator_reg <= INDICATOR_RST; // see RULE6
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Upper register read image
   always_ff @(posedge clock) begin
      if (reset) begin
         channel_control_status <= 8'h00;
      end else begin
         channel_control_status <= {ctrl_reg.scan_all, ctrl_reg.single_en, ctrl_reg.select,
                                    (scan_pulse ? (next_valid ? 4'h1 << next_chan : INDICATOR_RST)
                                                : indicator_reg)}; // see RULE13 see RULE4
      end
   end

endmodule : adsp_scan_port

// ---- adsp_scan_port_monitor.sv ----
// Port checker of the converter scan port
`timescale 1ns/100ps
module adsp_scan_port_monitor (
   input wire logic clock,
   input wire logic reset,
   input wire logic scan_pulse,
   input wire logic image_out_wr,
   input wire logic [7:0] image_out_data,
   input wire logic [7:0] conversion_data,
   input wire logic [7:0] channel_control_status,
   input wire logic conv_req,
   input wire logic [1:0] conv_channel
);
   logic [7:0] s;
   logic prev_all_reg;
   assign s = channel_control_status;
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   // Mode seen at the last scan, so rotation is told apart from mode entry
   always_ff @(posedge clock) begin
      if (reset) begin
         prev_all_reg <= 1'b0;
      end else if (scan_pulse) begin
         prev_all_reg <= s[7];
      end
   end
   ////////////////////////////////////////////////////////////
   AST_ONE_HOT: assert property ($onehot0(s[3:0]))
      else $error("indicators not one-hot");
   AST_IND_HOLD: assert property (!$past(scan_pulse) |-> $stable(s[3:0]))
      else $error("indicators moved without scan");
   AST_DATA_HOLD: assert property (!$past(scan_pulse) |-> $stable(conversion_data))
      else $error("data moved without scan");
   AST_WRITE_ECHO: assert property (image_out_wr |-> ##2 s[7:4] == $past(image_out_data[7:4], 2))
      else $error("output points not echoed");
   AST_ALL_ENTRY: assert property (scan_pulse && s[7] && !prev_all_reg && !$past(image_out_wr)
      |=> s[3:0] == 4'h1)
      else $error("scan-all did not start at channel 1");
   AST_ALL_ROTATE: assert property (scan_pulse && s[7] && prev_all_reg && !$past(image_out_wr)
      |=> s[3:0] == {$past(s[2:0]), $past(s[3])})
      else $error("scan-all rotation broken");
   AST_SINGLE_SEL: assert property (scan_pulse && !s[7] && s[6] && !$past(image_out_wr)
      |=> s[3:0] == 4'h1 << s[5:4])
      else $error("single select wrong channel");
   AST_NONE_SHOWN: assert property (scan_pulse && !s[7] && !s[6] && !$past(image_out_wr)
      |=> s[3:0] == 4'h0)
      else $error("indicator shown with nothing selected");
   AST_CHAN_HOLD: assert property (conv_req && $past(conv_req) |-> $stable(conv_channel))
      else $error("channel moved during request");
endmodule : adsp_scan_port_monitor

bind adsp_scan_port adsp_scan_port_monitor u_adsp_scan_port_monitor (.clock(clock), .reset(reset),
   .scan_pulse(scan_pulse), .image_out_wr(image_out_wr), .image_out_data(image_out_data),
   .conversion_data(conversion_data), .channel_control_status(channel_control_status),
   .conv_req(conv_req), .conv_channel(conv_channel));

// ---- adsp_conv_model.sv ----
// Behavioural converter at the far side of the scan port
`timescale 1ns/100ps
module adsp_conv_model (
   input wire logic clock,
   input wire logic conv_req,
   input wire logic [1:0] conv_channel,
   input wire logic [31:0] chan_vals,
   input wire logic [7:0] delay,
   output logic conv_ack,
   output logic [7:0] conv_data
);
   logic [7:0] cnt_reg = 8'h00;
   initial conv_ack = 1'b0;
   initial conv_data = 8'h5a;
   ////////////////////////////////////////////////////////////
   always @(posedge clock) begin
      if (conv_req && !conv_ack) begin
         cnt_reg <= cnt_reg + 8'h01;
         if (cnt_reg >= delay) begin
            cnt_reg <= 8'h00;
            conv_ack <= 1'b1;
            conv_data <= chan_vals[conv_channel * 8 +: 8];
         end
      end else if (!conv_req && conv_ack) begin
         conv_ack <= 1'b0;
         // Released data is not held, so a late sample shows up
         conv_data <= ~conv_data;
      end else if (!conv_req) begin
         // An abandoned request starts its count afresh
         cnt_reg <= 8'h00;
      end
   end
endmodule : adsp_conv_model

// ---- adsp_scan_port_bench.sv ----
// Testbench of the converter scan port
`timescale 1ns/100ps
module adsp_scan_port_bench;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic scan_pulse = 1'b0;
   logic image_out_wr = 1'b0;
   logic [7:0] image_out_data = 8'h00;
   logic [7:0] conversion_data;
   logic [7:0] channel_control_status;
   logic conv_req;
   logic [1:0] conv_channel;
   logic conv_ack;
   logic [7:0] conv_data;
   logic [7:0] delay = 8'h03;
   // Extreme codes and the top weight alone
   logic [31:0] chan_vals = 32'h01_80_ff_00;
   int err_count = 0;
   int checks_done = 0;
   initial forever #5 clock = ~clock;
   adsp_scan_port #(.CONV_TIMEOUT(50)) u_adsp_scan_port (.clock(clock), .reset(reset),
      .scan_pulse(scan_pulse), .image_out_wr(image_out_wr), .image_out_data(image_out_data),
      .conversion_data(conversion_data), .channel_control_status(channel_control_status),
      .conv_req(conv_req), .conv_channel(conv_channel), .conv_ack(conv_ack), .conv_data(conv_data));
   adsp_conv_model u_adsp_conv_model (.clock(clock), .conv_req(conv_req), .conv_channel(conv_channel),
      .chan_vals(chan_vals), .delay(delay), .conv_ack(conv_ack), .conv_data(conv_data));
   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] d);
      @(posedge clock);
      image_out_wr <= 1'b1;
      image_out_data <= d;
      @(posedge clock);
      image_out_wr <= 1'b0;
      repeat (2) @(posedge clock);
   endtask : wr
   task automatic sc(input logic [7:0] st, input logic [7:0] d);
      @(posedge clock);
      scan_pulse <= 1'b1;
      @(posedge clock);
      scan_pulse <= 1'b0;
      @(posedge clock);
      #1;
      chk(channel_control_status, st);
      chk(conversion_data, d);
   endtask : sc
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : final_report
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clock);
      reset <= 1'b0;
      repeat (100) @(posedge clock);
      sc(8'h00, 8'h00);
      $display("idle scan done");
      wr(8'h80);
      for (int i = 0; i < 5; i++) begin
         sc(8'h80 | (8'h01 << (i % 4)), chan_vals[(i % 4) * 8 +: 8]);
      end
      wr(8'hf0);
      sc(8'hf2, chan_vals[15:8]);
      $display("scan-all done");
      // Slow converter and new inputs: results must refresh between scans
      @(posedge clock);
      delay <= 8'h28;
      chan_vals <= 32'h10_20_40_7f;
      repeat (300) @(posedge clock);
      for (int s = 0; s < 4; s++) begin
         wr(8'h40 | 8'(s << 4));
         repeat (2) sc(8'h40 | 8'(s << 4) | 8'(1 << s), chan_vals[s * 8 +: 8]);
      end
      wr(8'h00);
      sc(8'h00, chan_vals[31:24]);
      $display("single select done");
      // Stuck converter: every request times out, so slots keep their last result
      @(posedge clock);
      delay <= 8'hff;
      chan_vals <= 32'h11_22_33_44;
      repeat (200) @(posedge clock);
      wr(8'h40);
      sc(8'h41, 8'h7f);
      @(posedge clock);
      delay <= 8'h03;
      repeat (150) @(posedge clock);
      sc(8'h41, chan_vals[7:0]);
      $display("timeout recovery done");
      final_report();
   end
endmodule : adsp_scan_port_bench
